// ===== verilog/sbac_arbiter.sv
`default_nettype none
// How it works
// [RULE1] Nine-bit counter plus separate overflow bit
// [RULE2] Mode field: idle, measure, arbitrate, reserved
// [RULE3] Mode bits writable, readable, reset to idle
// [RULE4] Lost flag cleared by writing upper mode zero
// [RULE5] Clock select: prescaler quarter or bus quarter
// [RULE6] Prescaler source picked by configuration bit
// [RULE7] Finished flag set at stop, write clears
// [RULE8] Running flag shows counter counting
// [RULE9] Overflow flag cleared by any control write
// [RULE10] Idle mode holds counter at zero
// [RULE11] Counter MSB readable, cleared by write
// [RULE12] Low byte register, cleared by write
// [RULE13] Bus-clock measure: falling edge to falling edge
// [RULE14] Prescaler measure: low level to rising edge
// [RULE15] Arbitrate: restart on transmit rise, sample receive
// [RULE16] Lost forces transmit high; early low resets
// [RULE17] Wrap from maximum sets sticky overflow
module sbac_arbiter #(
  parameter int AW = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_pin,
  input wire logic serializer_tx_out,
  input wire logic baud_source_sel,
  input wire logic bus_presc_tick,
  input wire logic osc_presc_tick,
  output logic tx_pin,
  output logic irq
);
  sbac_pkg::sbac_ctl_t ctl_ff;
  sbac_pkg::sbac_state_t state_ff;
  logic [8:0] cnt_ff;
  logic [1:0] div_ff;
  logic [2:0] rx_q_ff;
  logic rx_st_ff;
  logic rx_prev_ff;
  logic tx_prev_ff;
  logic lost_ff;
  logic done_ff;
  logic ovf_ff;
  logic [sbac_pkg::IRQ_W-1:0] stat_ff;
  logic [sbac_pkg::IRQ_W-1:0] mask_ff;
  logic [7:0] rdata_ff;
  logic tx_pin_ff;
  logic irq_ff;

  logic ctrl_wr;
  logic presc_tick;
  logic base_tick;
  logic tick;
  logic rx_fall;
  logic rx_rise;
  logic tx_rise;
  logic tx_fall;
  logic is_meas;
  logic is_arb;
  logic running;
  logic start_ev;
  logic stop_ev;
  logic abort_ev;
  logic sample_ev;
  logic lost_set;
  logic ovf_set;
  logic [8:0] smp_val;
  logic [7:0] ctrl_view;
  logic [sbac_pkg::IRQ_W-1:0] ev_vec;
  sbac_pkg::sbac_mode_t wr_mode;

  assign ctrl_wr = reg_wr && (reg_addr == sbac_pkg::OFS_CTRL);
  assign wr_mode = sbac_pkg::sbac_mode_t'(reg_wdata[sbac_pkg::BIT_MODE_HI:sbac_pkg::BIT_MODE_LO]);
  assign is_meas = (ctl_ff.mode == sbac_pkg::SBAC_MODE_MEAS);
  assign is_arb = (ctl_ff.mode == sbac_pkg::SBAC_MODE_ARB);
  assign running = (state_ff == sbac_pkg::SBAC_ST_RUN);
  // [RULE6] Prescaler source select
  assign presc_tick = baud_source_sel ? osc_presc_tick : bus_presc_tick;
  // [RULE5] Counter clock select
  assign base_tick = ctl_ff.clk_sel ? presc_tick : 1'b1;
  assign tick = base_tick && (div_ff == sbac_pkg::DIV_LAST);
  assign rx_fall = rx_prev_ff && !rx_st_ff;
  assign rx_rise = !rx_prev_ff && rx_st_ff;
  assign tx_rise = !tx_prev_ff && serializer_tx_out;
  assign tx_fall = tx_prev_ff && !serializer_tx_out;
  assign smp_val = ctl_ff.clk_sel ? sbac_pkg::SMP_PRESC : sbac_pkg::SMP_BUS;
  // [RULE13] [RULE14] Measurement start, and arbitration start on transmit rise
  assign start_ev = (state_ff == sbac_pkg::SBAC_ST_WAIT) && !ctrl_wr &&
                    ((is_meas && (ctl_ff.clk_sel ? !rx_st_ff : rx_fall)) ||
                     (is_arb && tx_rise));
  // [RULE13] [RULE14] Measurement stop
  assign stop_ev = running && is_meas && !ctrl_wr &&
                   (ctl_ff.clk_sel ? rx_rise : rx_fall);
  // [RULE16] Early transmit low aborts the bit
  assign abort_ev = running && is_arb && !ctrl_wr && tx_fall && !lost_ff;
  // [RULE15] Sample receive as the count reaches the sample point
  assign sample_ev = running && is_arb && !ctrl_wr && tick && !tx_rise &&
                     (cnt_ff == smp_val - 9'h001);
  assign lost_set = sample_ev && !rx_st_ff;
  // [RULE17] Wrap detect
  // A stop or restart on the same tick freezes or clears the count, so no wrap
  assign ovf_set = running && tick && !ctrl_wr && !stop_ev && !abort_ev &&
                   !(is_arb && tx_rise) &&
                   (cnt_ff == sbac_pkg::CNT_MAX);

  // Receive pin synchroniser and stable level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q_ff <= 3'h7;
      rx_st_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_q_ff <= {rx_q_ff[1:0], rx_pin};
      if (rx_q_ff[1] == rx_q_ff[2]) begin
        rx_st_ff <= rx_q_ff[2];
      end
      rx_prev_ff <= rx_st_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_prev_ff <= 1'b1;
      div_ff <= 2'h0;
    end else begin
      tx_prev_ff <= serializer_tx_out;
      if (base_tick) begin
        div_ff <= div_ff + 2'h1;
      end
    end
  end

  // [RULE3] [RULE5] Mode and clock select bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff <= '{mode: sbac_pkg::SBAC_MODE_IDLE, clk_sel: 1'b0};
    end else if (ctrl_wr) begin
      ctl_ff <= '{mode: wr_mode, clk_sel: reg_wdata[sbac_pkg::BIT_CLK_SEL]};
    end
  end

  // [RULE2] [RULE8] Counter sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= sbac_pkg::SBAC_ST_IDLE;
    end else if (ctrl_wr) begin
      state_ff <= (wr_mode == sbac_pkg::SBAC_MODE_IDLE) ? sbac_pkg::SBAC_ST_IDLE
                                                         : sbac_pkg::SBAC_ST_WAIT;
    end else begin
      case (state_ff)
        sbac_pkg::SBAC_ST_IDLE: begin
          if (ctl_ff.mode != sbac_pkg::SBAC_MODE_IDLE) begin
            state_ff <= sbac_pkg::SBAC_ST_WAIT;
          end
        end
        sbac_pkg::SBAC_ST_WAIT: begin
          if (start_ev) begin
            state_ff <= sbac_pkg::SBAC_ST_RUN;
          end
        end
        sbac_pkg::SBAC_ST_RUN: begin
          if (stop_ev) begin
            state_ff <= sbac_pkg::SBAC_ST_DONE;
          end else if (abort_ev) begin
            state_ff <= sbac_pkg::SBAC_ST_WAIT;
          end
        end
        sbac_pkg::SBAC_ST_DONE: begin
          state_ff <= sbac_pkg::SBAC_ST_DONE;
        end
        default: begin
          state_ff <= sbac_pkg::SBAC_ST_IDLE;
        end
      endcase
    end
  end

  // [RULE1] [RULE10] [RULE11] [RULE12] Counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= sbac_pkg::CNT_ZERO;
    end else if (ctrl_wr || ctl_ff.mode == sbac_pkg::SBAC_MODE_IDLE) begin
      cnt_ff <= sbac_pkg::CNT_ZERO;
    end else if (abort_ev || (running && is_arb && tx_rise)) begin
      cnt_ff <= sbac_pkg::CNT_ZERO;
    end else if (start_ev) begin
      cnt_ff <= sbac_pkg::CNT_ZERO;
    end else if (running && tick && !stop_ev) begin
      cnt_ff <= cnt_ff + 9'h001;
    end
  end

  // [RULE7] [RULE9] [RULE17] Sticky flags, set wins over write clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else begin
      done_ff <= stop_ev || (done_ff && !ctrl_wr);
      ovf_ff <= ovf_set || (ovf_ff && !ctrl_wr);
    end
  end

  // [RULE4] Lost flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lost_ff <= 1'b0;
    end else if (lost_set) begin
      lost_ff <= 1'b1;
    end else if (ctrl_wr && !reg_wdata[sbac_pkg::BIT_MODE_HI]) begin
      lost_ff <= 1'b0;
    end
  end

  // [RULE16] Transmit pin forced high while lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin_ff <= 1'b1;
    end else begin
      tx_pin_ff <= serializer_tx_out || lost_ff;
    end
  end

  // Interrupt status, mask and output
  assign ev_vec = {lost_set, ovf_set, stop_ev};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= '0;
      mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == sbac_pkg::OFS_IRQ_STAT) begin
        stat_ff <= ev_vec | (stat_ff & ~reg_wdata[sbac_pkg::IRQ_W-1:0]);
      end else begin
        stat_ff <= ev_vec | stat_ff;
      end
      if (reg_wr && reg_addr == sbac_pkg::OFS_IRQ_MASK) begin
        mask_ff <= reg_wdata[sbac_pkg::IRQ_W-1:0];
      end
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // [RULE11] Control register view
  assign ctrl_view = {ctl_ff.mode, lost_ff, ctl_ff.clk_sel, done_ff, running, ovf_ff,
                      cnt_ff[8]};

  // Register read port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= sbac_pkg::RST_BYTE;
    end else if (!reg_rd) begin
      rdata_ff <= sbac_pkg::RST_BYTE;
    end else if (reg_addr == sbac_pkg::OFS_CTRL) begin
      rdata_ff <= ctrl_view;
    end else if (reg_addr == sbac_pkg::OFS_CNT_LOW) begin
      rdata_ff <= cnt_ff[7:0];
    end else if (reg_addr == sbac_pkg::OFS_IRQ_STAT) begin
      rdata_ff <= {5'h00, stat_ff};
    end else if (reg_addr == sbac_pkg::OFS_IRQ_MASK) begin
      rdata_ff <= {5'h00, mask_ff};
    end else begin
      rdata_ff <= sbac_pkg::RST_BYTE;
    end
  end

  assign reg_rdata = rdata_ff;
  assign tx_pin = tx_pin_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_idle_cnt_zero: assert property ( // [RULE10]
    (ctl_ff.mode == sbac_pkg::SBAC_MODE_IDLE) |=> (cnt_ff == sbac_pkg::CNT_ZERO) && !running)
    else $error("counter not held at zero in idle");
  a_write_clears_cnt: assert property ( // [RULE12]
    ctrl_wr |=> (cnt_ff == sbac_pkg::CNT_ZERO) && !ctrl_view[sbac_pkg::BIT_MSB])
    else $error("control write did not clear counter");
  a_write_clears_flags: assert property ( // [RULE9]
    ctrl_wr ##1 !stop_ev && !ovf_set |=> !done_ff && !ovf_ff)
    else $error("control write did not clear flags");
  a_lost_forces_tx: assert property ( // [RULE16]
    lost_ff |=> tx_pin_ff)
    else $error("transmit pin not forced high while lost");
  a_lost_clear: assert property ( // [RULE4]
    ctrl_wr && !reg_wdata[sbac_pkg::BIT_MODE_HI] && !lost_set |=> !lost_ff)
    else $error("lost flag not cleared");
  a_lost_sample: assert property ( // [RULE15]
    lost_set |=> lost_ff ##1 tx_pin_ff)
    else $error("low sample did not set lost");
  a_overflow_set: assert property ( // [RULE17]
    ovf_set |=> ovf_ff && (cnt_ff == sbac_pkg::CNT_ZERO))
    else $error("wrap did not set overflow");
  a_meas_start: assert property ( // [RULE13]
    is_meas && !ctl_ff.clk_sel && (state_ff == sbac_pkg::SBAC_ST_WAIT) && rx_fall && !ctrl_wr
    |=> running && ctrl_view[sbac_pkg::BIT_RUN])
    else $error("measurement did not start on falling edge");
  a_meas_stop: assert property ( // [RULE7]
    stop_ev |=> done_ff && !running ##1 done_ff || $past(ctrl_wr))
    else $error("measurement stop did not finish");
  a_read_low: assert property ( // [RULE12]
    reg_rd && (reg_addr == sbac_pkg::OFS_CNT_LOW) |=> rdata_ff == $past(cnt_ff[7:0]))
    else $error("low count read mismatch");
  a_irq_level: assert property (
    (|(stat_ff & mask_ff)) |=> irq_ff)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

// ===== verilog/sbac_pkg.sv
`default_nettype none
package sbac_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CNT_LOW = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
  // Control register field positions
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_LOST = 5;
  localparam int BIT_CLK_SEL = 4;
  localparam int BIT_DONE = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_OVF = 1;
  localparam int BIT_MSB = 0;
  // Interrupt status field positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_LOST = 2;
  localparam int IRQ_W = 3;
  // Reset values and counts
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [8:0] CNT_ZERO = 9'h000;
  localparam logic [8:0] CNT_MAX = 9'h1FF;
  localparam logic [8:0] SMP_BUS = 9'h038;
  localparam logic [8:0] SMP_PRESC = 9'h008;
  localparam logic [1:0] DIV_LAST = 2'h3;
  // Arbiter modes
  typedef enum logic [1:0] {
    SBAC_MODE_IDLE = 2'h0,
    SBAC_MODE_MEAS = 2'h1,
    SBAC_MODE_ARB = 2'h2,
    SBAC_MODE_RSVD = 2'h3
  } sbac_mode_t;
  // Counter sequencer states
  typedef enum logic [3:0] {
    SBAC_ST_IDLE = 4'b0001,
    SBAC_ST_WAIT = 4'b0010,
    SBAC_ST_RUN = 4'b0100,
    SBAC_ST_DONE = 4'b1000
  } sbac_state_t;
  // Software-held control bits
  typedef struct packed {
    sbac_mode_t mode;
    logic clk_sel;
  } sbac_ctl_t;
endpackage
`default_nettype wire

// ===== testbench/sbac_bus_node.sv
`default_nettype none
module sbac_bus_node (
  input wire logic tx_pin,
  input wire logic dominant,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Shared wire with pull-up, any node driving low wins
  assign rx_pin = tx_pin & ~dominant;
endmodule
`default_nettype wire

// ===== testbench/sbac_arbiter_tb.sv
`default_nettype none
module sbac_arbiter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic txo = 1'b1;
  logic bsrc = 1'b0;
  logic btick = 1'b0;
  logic otick = 1'b0;
  logic dom = 1'b0;
  logic [3:0] pc = 4'h0;
  logic [7:0] reg_rdata;
  logic [7:0] d;
  logic tx_pin;
  logic irq;
  logic rx_pin;
  int err_total = 0;
  int checked = 0;
  int i;
  logic [7:0] rw [7] = '{8'h10, 8'h3F, 8'h40, 8'h50, 8'h80, 8'hC0, 8'h00};
  logic [7:0] re [7] = '{8'h10, 8'h10, 8'h40, 8'h50, 8'h80, 8'hC0, 8'h00};

  sbac_arbiter dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
    .serializer_tx_out(txo), .baud_source_sel(bsrc), .bus_presc_tick(btick),
    .osc_presc_tick(otick), .tx_pin(tx_pin), .irq(irq)
  );
  sbac_bus_node node_u (.tx_pin(tx_pin), .dominant(dom), .rx_pin(rx_pin));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // Prescaler ticks: bus source every 2 cycles, oscillator source every 3
  always @(posedge ref_clk) begin
    pc <= (pc == 4'h5) ? 4'h0 : pc + 4'h1;
    btick <= pc[0];
    otick <= (pc == 4'h0) || (pc == 4'h3);
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
    @(posedge ref_clk);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk("reg_rdata", {1'b0, v}, {1'b0, e});
  endtask

  task automatic rng(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    chk("count_low_byte", {8'h00, v >= lo && v <= hi}, 9'h001);
  endtask

  task automatic poll(input int b, input logic e);
    logic [7:0] v;
    int n;
    for (n = 0; n < 600; n++) begin
      rd(sbac_pkg::OFS_CTRL, v);
      if (v[b] === e) break;
    end
    chk("control_flag", {8'h00, v[b]}, {8'h00, e});
    if (v[b] !== e) finish_test();
  endtask

  initial begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(1);
    rdc(sbac_pkg::OFS_CTRL, 8'h00);
    rdc(sbac_pkg::OFS_CNT_LOW, 8'h00);
    chk("irq", {8'h00, irq}, 9'h000);
    for (i = 0; i < 7; i++) begin
      wr(sbac_pkg::OFS_CTRL, rw[i]);
      rdc(sbac_pkg::OFS_CTRL, re[i]);
    end
    rdc(4'h2, 8'h00);
    $display("register test done");
    wr(sbac_pkg::OFS_CTRL, 8'h40);
    wr(sbac_pkg::OFS_IRQ_MASK, 8'h01);
    dom <= 1'b1;
    cyc(50);
    rdc(sbac_pkg::OFS_CTRL, 8'h44);
    cyc(48);
    dom <= 1'b0;
    cyc(100);
    dom <= 1'b1;
    poll(sbac_pkg::BIT_DONE, 1'b1);
    rdc(sbac_pkg::OFS_CTRL, 8'h48);
    rd(sbac_pkg::OFS_CNT_LOW, d);
    rng(d, 8'd49, 8'd51);
    chk("irq", {8'h00, irq}, 9'h001);
    wr(sbac_pkg::OFS_IRQ_MASK, 8'h00);
    // Let the registered interrupt settle before looking at it
    cyc(1);
    chk("irq", {8'h00, irq}, 9'h000);
    wr(sbac_pkg::OFS_IRQ_STAT, 8'h01);
    wr(sbac_pkg::OFS_IRQ_MASK, 8'h01);
    cyc(1);
    chk("irq", {8'h00, irq}, 9'h000);
    dom <= 1'b0;
    wr(sbac_pkg::OFS_CTRL, 8'h00);
    rdc(sbac_pkg::OFS_CTRL, 8'h00);
    rdc(sbac_pkg::OFS_CNT_LOW, 8'h00);
    $display("measure test done");
    wr(sbac_pkg::OFS_CTRL, 8'h40);
    dom <= 1'b1;
    poll(sbac_pkg::BIT_MSB, 1'b1);
    poll(sbac_pkg::BIT_OVF, 1'b1);
    wr(sbac_pkg::OFS_CTRL, 8'h40);
    rd(sbac_pkg::OFS_CTRL, d);
    chk("overflow_msb", {7'h00, d[1:0]}, 9'h000);
    wr(sbac_pkg::OFS_CTRL, 8'h00);
    $display("overflow test done");
    wr(sbac_pkg::OFS_CTRL, 8'h50);
    cyc(158);
    dom <= 1'b0;
    poll(sbac_pkg::BIT_DONE, 1'b1);
    rd(sbac_pkg::OFS_CNT_LOW, d);
    rng(d, 8'd18, 8'd22);
    wr(sbac_pkg::OFS_CTRL, 8'h00);
    $display("break test done");
    bsrc <= 1'b1;
    wr(sbac_pkg::OFS_CTRL, 8'h90);
    txo <= 1'b0;
    cyc(2);
    txo <= 1'b1;
    dom <= 1'b1;
    poll(sbac_pkg::BIT_LOST, 1'b1);
    txo <= 1'b0;
    wr(sbac_pkg::OFS_CTRL, 8'h90);
    rd(sbac_pkg::OFS_CTRL, d);
    chk("lost_flag", {8'h00, d[5]}, 9'h001);
    chk("tx_pin", {8'h00, tx_pin}, 9'h001);
    wr(sbac_pkg::OFS_CTRL, 8'h10);
    rdc(sbac_pkg::OFS_CTRL, 8'h10);
    chk("tx_pin", {8'h00, tx_pin}, 9'h000);
    dom <= 1'b0;
    wr(sbac_pkg::OFS_CTRL, 8'h80);
    txo <= 1'b1;
    cyc(40);
    txo <= 1'b0;
    cyc(3);
    rdc(sbac_pkg::OFS_CTRL, 8'h80);
    rdc(sbac_pkg::OFS_CNT_LOW, 8'h00);
    txo <= 1'b1;
    cyc(260);
    dom <= 1'b1;
    cyc(20);
    rd(sbac_pkg::OFS_CTRL, d);
    chk("lost_flag", {8'h00, d[5]}, 9'h000);
    dom <= 1'b0;
    $display("arbitration test done");
    // Reset in mid-run while the counter is running in arbitration mode
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    rdc(sbac_pkg::OFS_CTRL, 8'h00);
    rdc(sbac_pkg::OFS_CNT_LOW, 8'h00);
    rdc(sbac_pkg::OFS_IRQ_MASK, 8'h00);
    $display("reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
